// file: lcdac_pkg.sv
// lcdac_pkg: constants for the display attribute control block
package lcdac_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ACNT_OFS = 8'h04;
  localparam logic [7:0] LED_IDX = 8'h03;
  localparam logic [7:0] LED_OFS = 8'(LED_IDX * 4);
  localparam logic [7:0] STAT_OFS = 8'h10;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int HL_EN_POS = 0;
  localparam int INV_POS = 1;
  localparam int UND_POS = 2;
  localparam int FLS_POS = 3;
  localparam int GW_POS = 4;
  localparam int QCK_POS = 5;
  localparam int POFF_POS = 6;
  localparam int NL_POS = 7;
  localparam int TALL_POS = 9;
  localparam int KSEL_POS = 12;
  localparam logic [13:0] CTRL_RST = 14'h0180;
  localparam logic [6:0] ACNT_RST = 7'h00;
  localparam logic [5:0] LED_RST = 6'h00;
  // ****************************************
  // line and mode codes
  // ****************************************
  localparam logic [1:0] NL_TWO = 2'h1;
  localparam logic [1:0] NL_THREE = 2'h2;
  localparam logic [1:0] NL_FOUR = 2'h3;
  localparam logic [2:0] LAST_LINE = 3'h4;
  localparam logic [3:0] LAST_CHAR = 4'hB;
  localparam logic [3:0] CHARS_FIVE_DOT = 4'hC;
  localparam logic [3:0] CHARS_SIX_DOT = 4'hA;
  // ****************************************
  // timing
  // ****************************************
  localparam int PCLK_KHZ = 250000;
  localparam int OSC_KHZ = 160;
  localparam int OSC_DIV = PCLK_KHZ / OSC_KHZ;
  localparam int QUARTER_DIV = 4;
  localparam int LINE_CLKS = 60;
  localparam int DUTY_NORMAL = 34;
  localparam int DUTY_PARTIAL = 10;
  localparam int FLASH_FRAMES = 32;
  localparam int FLASH_HALF = FLASH_FRAMES / 2;
  localparam int KSCAN_NORMAL = 320;
  localparam int KSCAN_PARTIAL = 160;
endpackage : lcdac_pkg

// file: lcdac_div.sv
// lcdac_div: enable-counting divider giving a one-cycle tick per period
module lcdac_div #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // count control
  input wire logic en,
  input wire logic [W-1:0] period,
  // tick out
  output logic tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic wrap;

  assign wrap = en && (cnt_q >= period - W'(1));
  assign cnt_d = wrap ? '0 : (en ? cnt_q + W'(1) : cnt_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick <= wrap;
    end
  end
endmodule : lcdac_div

// file: lcdac_top.sv
// lcdac_top: line cursor, tall line, glyph width, led port and partial-off control
//
// Functional notes
// - highlight enable puts cursor attribute on whole line holding the address counter
// - three cursor styles: inverting flash, underline, plain flash
// - both flash styles repeat every 32 display frames
// - address 00-0B line 1 up to 40-4B line 5, twelve characters each
// - four-line mode tall codes: none, 1, 2, 1+2, 3; 101 and 110 disallowed
// - two-line mode odd codes double line 1; 010 and 110 disallowed
// - three-line mode 001/101 line 1, 010/110 line 2; 011,100,111 disallowed
// - any glyph from rom or ram may be shown tall
// - width bit 0 gives 5-dot glyphs, 12 per line; 1 gives 6-dot, 10
// - tall rendering works together with six-dot wide glyphs
// - led outputs from bits 0-2, ports from 3-5 of byte 0011
// - quarter clock bit divides internal clock 160 kHz to 40 kHz
// - partial-off shows line 1 only, lines 2-4 held deselected
// - key scan 320-2560 clocks normal, 160-1280 partial, chosen by select bits
// - 1/34 duty normal, 1/10 duty partial
//
// The APB slave port was chosen for this implementation.
module lcdac_top #(
  parameter int OSC_CYCLES = lcdac_pkg::OSC_DIV
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cursor attributes
  output logic [4:0] hl_line,
  output logic cur_invert,
  output logic cur_underline,
  output logic cur_blank,
  // glyph rendering
  output logic [2:0] tall_line,
  output logic glyph_six_dot,
  output logic [3:0] chars_per_line,
  // common drive
  output logic [3:0] com_deselect,
  output logic [5:0] com_index,
  output logic line_tick,
  output logic frame_tick,
  output logic key_scan_tick,
  // led and general ports
  output logic [2:0] led_out,
  output logic [2:0] gen_port
);
  // ****************************************
  // registers and apb decode
  // ****************************************
  logic [13:0] ctrl_q;
  logic [6:0] address_counter_q;
  logic [5:0] led_and_port_outputs_q;
  logic [31:0] rdata_q, rd_mux, status;
  logic ready_q, err_q, setup, wr_done, mapped;
  logic sel_ctrl, sel_acnt, sel_led, sel_stat;
  assign setup = psel && !penable && !ready_q;
  assign wr_done = psel && penable && ready_q && pwrite;
  assign sel_ctrl = paddr == lcdac_pkg::CTRL_OFS;
  assign sel_acnt = paddr == lcdac_pkg::ACNT_OFS;
  assign sel_led = paddr == lcdac_pkg::LED_OFS;
  assign sel_stat = paddr == lcdac_pkg::STAT_OFS;
  assign mapped = sel_ctrl || sel_acnt || sel_led || sel_stat;

  always_comb
  begin
    if (sel_ctrl)
      rd_mux = {18'h00000, ctrl_q};
    else if (sel_acnt)
      rd_mux = {25'h0000000, address_counter_q};
    else if (sel_led)
      rd_mux = {26'h0000000, led_and_port_outputs_q};
    else if (sel_stat)
      rd_mux = status;
    else
      rd_mux = 32'h00000000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_q <= 1'b0;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end
    else
    begin
      ready_q <= setup;
      rdata_q <= setup ? rd_mux : 32'h00000000;
      err_q <= setup && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= lcdac_pkg::CTRL_RST;
      address_counter_q <= lcdac_pkg::ACNT_RST;
      led_and_port_outputs_q <= lcdac_pkg::LED_RST;
    end
    else if (wr_done)
    begin
      if (sel_ctrl)
        ctrl_q <= pwdata[13:0];
      if (sel_acnt)
        address_counter_q <= pwdata[6:0];
      if (sel_led)
        led_and_port_outputs_q <= pwdata[5:0];
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;

  // ****************************************
  // control fields
  // ****************************************
  logic line_highlight_enable, invert_sel, underline_sel, flash_sel;
  logic glyph_width_select, quarter_clock_select, partial_off;
  logic [1:0] line_count, scan_period_select;
  logic [2:0] tall_code;
  assign line_highlight_enable = ctrl_q[lcdac_pkg::HL_EN_POS];
  assign invert_sel = ctrl_q[lcdac_pkg::INV_POS];
  assign underline_sel = ctrl_q[lcdac_pkg::UND_POS];
  assign flash_sel = ctrl_q[lcdac_pkg::FLS_POS];
  assign glyph_width_select = ctrl_q[lcdac_pkg::GW_POS];
  assign quarter_clock_select = ctrl_q[lcdac_pkg::QCK_POS];
  assign partial_off = ctrl_q[lcdac_pkg::POFF_POS];
  assign line_count = ctrl_q[lcdac_pkg::NL_POS +: 2];
  assign tall_code = ctrl_q[lcdac_pkg::TALL_POS +: 3];
  assign scan_period_select = ctrl_q[lcdac_pkg::KSEL_POS +: 2];

  // ****************************************
  // clock and frame timing
  // ****************************************
  logic osc_tick, int_tick, line_w, frame_w, flash_w, key_w, com_wrap;
  logic [5:0] duty, com_q;
  logic [11:0] key_period, key_base;
  logic flash_phase_q;
  assign duty = partial_off ? 6'(lcdac_pkg::DUTY_PARTIAL) : 6'(lcdac_pkg::DUTY_NORMAL);
  assign key_base = partial_off ? 12'(lcdac_pkg::KSCAN_PARTIAL) : 12'(lcdac_pkg::KSCAN_NORMAL);
  assign key_period = key_base << scan_period_select;
  assign com_wrap = com_q >= duty - 6'h01;
  lcdac_div #(.W(12)) u_osc (
    .pclk(pclk), .presetn(presetn), .en(1'b1),
    .period(12'(OSC_CYCLES)), .tick(osc_tick)
  );
  lcdac_div #(.W(3)) u_quarter (
    .pclk(pclk), .presetn(presetn), .en(osc_tick),
    .period(quarter_clock_select ? 3'(lcdac_pkg::QUARTER_DIV) : 3'h1),
    .tick(int_tick)
  );
  lcdac_div #(.W(6)) u_line (
    .pclk(pclk), .presetn(presetn), .en(int_tick),
    .period(6'(lcdac_pkg::LINE_CLKS)), .tick(line_w)
  );
  lcdac_div #(.W(6)) u_frame (
    .pclk(pclk), .presetn(presetn), .en(line_w),
    .period(duty), .tick(frame_w)
  );
  lcdac_div #(.W(5)) u_flash (
    .pclk(pclk), .presetn(presetn), .en(frame_w),
    .period(5'(lcdac_pkg::FLASH_HALF)), .tick(flash_w)
  );
  lcdac_div #(.W(12)) u_key (
    .pclk(pclk), .presetn(presetn), .en(int_tick),
    .period(key_period), .tick(key_w)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      com_q <= 6'h00;
      flash_phase_q <= 1'b0;
    end
    else
    begin
      if (frame_w)
        com_q <= 6'h00;
      else if (line_w)
        com_q <= com_wrap ? 6'h00 : com_q + 6'h01;
      if (flash_w)
        flash_phase_q <= !flash_phase_q;
    end
  end

  // ****************************************
  // line cursor and tall line decode
  // ****************************************
  logic [2:0] ac_line, tall_d;
  logic [4:0] hl_d, hl_eff;
  logic ac_valid, tall_bad;
  logic [3:0] desel_d;
  assign ac_line = address_counter_q[6:4];
  assign ac_valid = (ac_line <= lcdac_pkg::LAST_LINE) && (address_counter_q[3:0] <= lcdac_pkg::LAST_CHAR);
  assign hl_d = (line_highlight_enable && ac_valid) ? 5'(5'h01 << ac_line) : 5'h00;
  assign hl_eff = partial_off ? (hl_d & 5'h01) : hl_d;

  always_comb
  begin
    tall_d = 3'h0;
    tall_bad = 1'b0;
    case (line_count)
      lcdac_pkg::NL_FOUR:
        case (tall_code)
          3'h1: tall_d = 3'h1;
          3'h2: tall_d = 3'h2;
          3'h3, 3'h7: tall_d = 3'h3;
          3'h4: tall_d = 3'h4;
          3'h5, 3'h6: tall_bad = 1'b1;
          default: tall_d = 3'h0;
        endcase
      lcdac_pkg::NL_TWO:
        if (tall_code[1:0] == 2'h2)
          tall_bad = 1'b1;
        else
          tall_d = {2'h0, tall_code[0]};
      lcdac_pkg::NL_THREE:
        case (tall_code)
          3'h1, 3'h5: tall_d = 3'h1;
          3'h2, 3'h6: tall_d = 3'h2;
          3'h3, 3'h4, 3'h7: tall_bad = 1'b1;
          default: tall_d = 3'h0;
        endcase
      default: tall_d = 3'h0;
    endcase
  end

  assign desel_d = partial_off ? 4'hE : 4'h0;
  assign status = {13'h0000, tall_bad, flash_phase_q, 2'h0, tall_line, hl_line, 1'b0, com_q};

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hl_line <= 5'h00;
      cur_invert <= 1'b0;
      cur_underline <= 1'b0;
      cur_blank <= 1'b0;
      tall_line <= 3'h0;
      glyph_six_dot <= 1'b0;
      chars_per_line <= lcdac_pkg::CHARS_FIVE_DOT;
      com_deselect <= 4'h0;
      com_index <= 6'h00;
      line_tick <= 1'b0;
      frame_tick <= 1'b0;
      key_scan_tick <= 1'b0;
      led_out <= 3'h0;
      gen_port <= 3'h0;
    end
    else
    begin
      hl_line <= hl_eff;
      cur_invert <= invert_sel && flash_phase_q && (hl_eff != 5'h00);
      cur_underline <= underline_sel && (hl_eff != 5'h00);
      cur_blank <= flash_sel && flash_phase_q && (hl_eff != 5'h00);
      tall_line <= partial_off ? (tall_d & 3'h1) : tall_d;
      glyph_six_dot <= glyph_width_select;
      chars_per_line <= glyph_width_select ? lcdac_pkg::CHARS_SIX_DOT : lcdac_pkg::CHARS_FIVE_DOT;
      com_deselect <= desel_d;
      com_index <= com_q;
      line_tick <= line_w;
      frame_tick <= frame_w;
      key_scan_tick <= key_w;
      led_out <= led_and_port_outputs_q[2:0];
      gen_port <= led_and_port_outputs_q[5:3];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  int unsigned osc_gap;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_gap <= 0;
    else if (int_tick)
      osc_gap <= 0;
    else
      osc_gap <= osc_gap + 1;
  end

  sequence apb_setup_s;
    psel && !penable && !pready;
  endsequence

  hl_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    (line_highlight_enable && !partial_off && address_counter_q == 7'h2B) ##1 1'b1 |-> hl_line == 5'h04)
    else $error("line 3 not highlighted");
  hl_none_a: assert property (@(posedge pclk) disable iff (!presetn)
    (address_counter_q[3:0] > 4'hB || address_counter_q[6:4] > 3'h4) |=> hl_line == 5'h00)
    else $error("highlight outside line range");
  hl_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !line_highlight_enable |=> hl_line == 5'h00 && !cur_underline)
    else $error("highlight without enable");
  tall_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    (line_count == 2'h3 && !partial_off && tall_code == 3'h7) |=> tall_line == 3'h3)
    else $error("four line tall code 111 wrong");
  tall_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (line_count == 2'h1 && !partial_off && tall_code == 3'h5) |=> tall_line == 3'h1)
    else $error("two line tall code wrong");
  tall_three_a: assert property (@(posedge pclk) disable iff (!presetn)
    (line_count == 2'h2 && tall_code inside {3'h3, 3'h4, 3'h7}) |=> tall_line == 3'h0)
    else $error("three line disallowed code shown");
  width_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
    glyph_width_select |=> chars_per_line == 4'hA && glyph_six_dot)
    else $error("six dot width not applied");
  led_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && sel_led) |=> ##1 led_out == $past(pwdata[2:0], 2) && gen_port == $past(pwdata[5:3], 2))
    else $error("led port mapping wrong");
  quarter_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (int_tick && quarter_clock_select && $stable(ctrl_q)) |-> osc_gap == lcdac_pkg::QUARTER_DIV * OSC_CYCLES - 1)
    else $error("quarter clock gap wrong");
  partial_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
    partial_off |=> com_deselect == 4'hE && hl_line[4:1] == 4'h0)
    else $error("partial lines not deselected");
  duty_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    com_q < 6'h22)
    else $error("common index past duty");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule : lcdac_top

// file: lcdac_panel_model.sv
// lcdac_panel_model: panel side, measures drive timing
module lcdac_panel_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // drive from the controller
  input wire logic line_tick,
  input wire logic frame_tick,
  input wire logic key_scan_tick,
  input wire logic cur_blank,
  // measured figures
  output int line_gap,
  output int key_gap,
  output int lines_per_frame,
  output int blank_frames,
  output int n_line,
  output int n_key,
  output int n_frame,
  output int n_blank
);
  timeunit 1ns;
  timeprecision 1ps;
  int line_cnt, key_cnt, lines_cnt, frames_b;
  logic blank_q;
  // ****************************************
  // tick spacing and frame counting
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {line_gap, key_gap, lines_per_frame, blank_frames} = '0;
      {n_line, n_key, n_frame, n_blank, line_cnt, key_cnt, lines_cnt, frames_b} = '0;
      blank_q = 1'b0;
    end
    else
    begin
      line_cnt++;
      key_cnt++;
      if (line_tick)
      begin
        line_gap = line_cnt; line_cnt = 0; lines_cnt++; n_line++;
      end
      if (key_scan_tick)
      begin
        key_gap = key_cnt; key_cnt = 0; n_key++;
      end
      if (frame_tick)
      begin
        lines_per_frame = lines_cnt; lines_cnt = 0; frames_b++; n_frame++;
      end
      if (cur_blank !== blank_q)
      begin
        blank_frames = frames_b; frames_b = 0; n_blank++; blank_q = cur_blank;
      end
    end
  end
endmodule : lcdac_panel_model

// file: lcdac_top_tb.sv
// lcdac_top_tb: register and display timing checks of lcdac_top
module lcdac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] hl_line;
  logic cur_invert, cur_underline, cur_blank, glyph_six_dot, line_tick, frame_tick, key_scan_tick;
  logic [2:0] tall_line, led_out, gen_port;
  logic [3:0] chars_per_line, com_deselect;
  logic [5:0] com_index;
  int line_gap, key_gap, lines_per_frame, blank_frames, n_line, n_key, n_frame, n_blank;
  int n_fail, checks;
  logic [31:0] tw [3];
  logic [23:0] bad;
  logic [63:0] hl_ac, hl_ex;
  // ****************************************
  // design and panel
  // ****************************************
  lcdac_top #(.OSC_CYCLES(2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hl_line, .cur_invert, .cur_underline, .cur_blank, .tall_line,
    .glyph_six_dot, .chars_per_line, .com_deselect, .com_index, .line_tick, .frame_tick,
    .key_scan_tick, .led_out, .gen_port);
  lcdac_panel_model u_panel (.pclk, .presetn, .line_tick, .frame_tick, .key_scan_tick, .cur_blank,
    .line_gap, .key_gap, .lines_per_frame, .blank_frames, .n_line, .n_key, .n_frame, .n_blank);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task stop_test;
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk); i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_fail++; $display("wrong value at %0t: no ready", $time); stop_test();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle
  function int cnt(input int which);
    case (which)
      0: return n_line;
      1: return n_key;
      2: return n_frame;
      default: return n_blank;
    endcase
  endfunction : cnt
  task wait_n(input int which, input int n);
    int start, i;
    start = cnt(which);
    for (i = 0; i < 50000 && cnt(which) < start + n; i++)
    begin
      @(posedge pclk); #1;
    end
    if (cnt(which) < start + n)
    begin
      n_fail++; $display("wrong value at %0t: wait ran out", $time); stop_test();
    end
  endtask : wait_n
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, n_fail, checks} = '0;
    tw = '{32'h1010_1010, 32'h0210_0210, 32'h3004_3210};
    bad = 24'h60_98_44;
    hl_ac = 64'h4C4B_3A2B_100C_0B00;
    hl_ex = 64'h0010_0804_0200_0101;
    repeat (6) @(posedge pclk);
    chk(chars_per_line, 32'hC);
    presetn <= 1'b1;
    apb(1'b0, lcdac_pkg::CTRL_OFS, 32'h0); chk(rd, 32'h180);
    apb(1'b0, lcdac_pkg::LED_OFS, 32'h0); chk(rd, 32'h0);
    apb(1'b1, lcdac_pkg::LED_OFS, 32'hFF); apb(1'b0, lcdac_pkg::LED_OFS, 32'h0); chk(rd, 32'h3F);
    apb(1'b1, lcdac_pkg::LED_OFS, 32'h15); settle();
    chk(led_out, 32'h5); chk(gen_port, 32'h2);
    apb(1'b1, 8'h08, 32'hFFFF_FFFF); chk(err, 32'h1);
    apb(1'b0, 8'h08, 32'h0); chk(err, 32'h1); chk(rd, 32'h0);
    apb(1'b1, lcdac_pkg::CTRL_OFS, 32'h185);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, lcdac_pkg::ACNT_OFS, 32'(hl_ac[8*i +: 8])); settle();
      chk(hl_line, 32'(hl_ex[8*i +: 5]));
    end
    chk(cur_underline, 32'h0);
    apb(1'b1, lcdac_pkg::ACNT_OFS, 32'h12); settle(); chk(cur_underline, 32'h1);
    apb(1'b1, lcdac_pkg::CTRL_OFS, 32'h184); settle();
    chk(hl_line, 32'h0); chk(cur_underline, 32'h0);
    for (int nl = 1; nl < 4; nl++)
      for (int c = 0; c < 8; c++)
      begin
        apb(1'b1, lcdac_pkg::CTRL_OFS, 32'(nl << 7 | c << 9 | 16)); settle();
        chk(tall_line, 32'(tw[nl-1][4*c +: 3]));
        apb(1'b0, lcdac_pkg::STAT_OFS, 32'h0); chk(rd[18], 32'(bad[8*(nl-1) + c]));
      end
    chk(glyph_six_dot, 32'h1); chk(chars_per_line, 32'hA);
    apb(1'b1, lcdac_pkg::CTRL_OFS, 32'h1C1); settle();
    chk(com_deselect, 32'hE); chk(hl_line, 32'h0);
    apb(1'b1, lcdac_pkg::ACNT_OFS, 32'h05); settle(); chk(hl_line, 32'h1);
    wait_n(2, 2); chk(lines_per_frame, 10);
    wait_n(1, 2); chk(key_gap, 320);
    apb(1'b1, lcdac_pkg::CTRL_OFS, 32'h1CB);
    wait_n(3, 1); chk(cur_invert, 32'h1); chk(cur_blank, 32'h1);
    wait_n(3, 1); chk(blank_frames, 16); chk(cur_invert, 32'h0);
    apb(1'b1, lcdac_pkg::CTRL_OFS, 32'h11A0);
    wait_n(0, 2); chk(line_gap, 480);
    wait_n(1, 2); chk(key_gap, 5120);
    apb(1'b1, lcdac_pkg::CTRL_OFS, 32'h180);
    wait_n(2, 2); chk(lines_per_frame, 34); chk(line_gap, 120);
    chk(com_index, 32'h0); chk(com_deselect, 32'h0);
    wait_n(0, 1); chk(com_index, 32'h1);
    wait_n(1, 2); chk(key_gap, 640);
    stop_test();
  end
endmodule : lcdac_top_tb
